// >>> logic/cbd_pkg.sv
// Shared constants of the capability bounds unit: register map, commands,
// status layout and metadata field placement.
// Assumes a 32-bit APB with byte addresses and one register per word.
package cbd_pkg;

  localparam int PADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_META_LO  = 8'h08;
  localparam logic [7:0] OFS_META_HI  = 8'h0c;
  localparam logic [7:0] OFS_ADDR_LO  = 8'h10;
  localparam logic [7:0] OFS_ADDR_HI  = 8'h14;
  localparam logic [7:0] OFS_TAG      = 8'h18;
  localparam logic [7:0] OFS_OPND_LO  = 8'h1c;
  localparam logic [7:0] OFS_OPND_HI  = 8'h20;
  localparam logic [7:0] OFS_REQB_LO  = 8'h24;
  localparam logic [7:0] OFS_REQB_HI  = 8'h28;
  localparam logic [7:0] OFS_REQT_LO  = 8'h2c;
  localparam logic [7:0] OFS_REQT_HI  = 8'h30;
  localparam logic [7:0] OFS_BASE_LO  = 8'h34;
  localparam logic [7:0] OFS_BASE_HI  = 8'h38;
  localparam logic [7:0] OFS_TOP_LO   = 8'h3c;
  localparam logic [7:0] OFS_TOP_HI   = 8'h40;
  localparam logic [7:0] OFS_TOP_EXT  = 8'h44;
  localparam logic [7:0] OFS_PCCM_LO  = 8'h48;
  localparam logic [7:0] OFS_PCCM_HI  = 8'h4c;
  localparam logic [7:0] OFS_PCCA_LO  = 8'h50;
  localparam logic [7:0] OFS_PCCA_HI  = 8'h54;

  // Commands, written to CMD[3:0]
  localparam logic [3:0] OP_NONE     = 4'h0;
  localparam logic [3:0] OP_CHECK    = 4'h1;
  localparam logic [3:0] OP_SET_ADDR = 4'h2;
  localparam logic [3:0] OP_AND_PERM = 4'h3;
  localparam logic [3:0] OP_BUILD    = 4'h4;
  localparam logic [3:0] OP_JUMP     = 4'h5;
  localparam logic [3:0] OP_LINK     = 4'h6;
  localparam int CMD_OP_W     = 4;
  localparam int CMD_REQT_BIT = 8;

  // STATUS bit positions
  localparam int ST_TAG       = 0;
  localparam int ST_MALFORMED = 1;
  localparam int ST_SEALED    = 2;
  localparam int ST_ACC_OK    = 3;
  localparam int ST_ACC_FAULT = 4;
  localparam int ST_TAG_LOST  = 5;
  localparam int ST_PCC_TAG   = 6;

  // Permission field, M-bit at bit 5
  localparam int PERM_W   = 6;
  localparam int PERM_C   = 0;
  localparam int PERM_WR  = 1;
  localparam int PERM_RD  = 2;
  localparam int PERM_X   = 3;
  localparam int PERM_SYSREG = 4;
  localparam int PERM_M   = 5;

  // Width sets per machine width
  localparam int MANT_W_32   = 10;
  localparam int MANT_W_64   = 14;
  localparam int EXP_W_32    = 5;
  localparam int EXP_W_64    = 6;
  localparam int SWPERM_W_32 = 2;
  localparam int SWPERM_W_64 = 4;

  // Metadata layout from bit 0: base mantissa, top mantissa without its two
  // top bits, extra top bit, exponent format flag, seal, permissions,
  // software permissions
  function automatic int xt_pos(int mant_w);
    return 2 * mant_w - 2;
  endfunction
  function automatic int ef_pos(int mant_w);
    return 2 * mant_w - 1;
  endfunction
  function automatic int seal_pos(int mant_w);
    return 2 * mant_w;
  endfunction
  function automatic int perm_lsb(int mant_w);
    return 2 * mant_w + 1;
  endfunction
  function automatic int swperm_lsb(int mant_w);
    return 2 * mant_w + 1 + PERM_W;
  endfunction

endpackage

// >>> logic/cbd_bounds_decode.sv
// Combinational decoder of compressed bounds into base and top.
// Assumes metadata laid out as in cbd_pkg and a machine width of 32 or 64.
`timescale 1ns/10ps
module cbd_bounds_decode #(
  parameter int MACHINE_WIDTH = 64
) (
  input  wire logic [MACHINE_WIDTH-1:0] meta,
  input  wire logic [MACHINE_WIDTH-1:0] addr,
  output logic      [MACHINE_WIDTH-1:0] base,
  output logic      [MACHINE_WIDTH:0]   top,
  output logic                          malformed
);
  localparam int  MX     = MACHINE_WIDTH;
  localparam bit  IS32   = (MX == 32);
  localparam int  MANT_W = IS32 ? cbd_pkg::MANT_W_32 : cbd_pkg::MANT_W_64;
  localparam int  EXP_W  = IS32 ? cbd_pkg::EXP_W_32 : cbd_pkg::EXP_W_64;
  localparam int  H      = EXP_W / 2;
  localparam int  MAXE   = MX - MANT_W + 2;
  localparam int  WIDE   = 2 * MX + 4;

  if (!(MX == 32 || MX == 64)) begin : g_width_check
    $error("cbd_bounds_decode: machine width must be 32 or 64");
  end

  logic [MANT_W-1:0] b_fld;
  logic [MANT_W-3:0] t_fld;
  logic              extra_top_bit;
  logic              exponent_format_flag;
  logic [2*H:0]      e_cat;
  logic signed [8:0] e_s;
  logic [7:0]        e_u;
  logic [MANT_W-1:0] b_mid;
  logic [MANT_W-1:0] t_full;
  logic [MANT_W-3:0] t_low;
  logic              length_carry;
  logic              length_top_bit;
  logic [1:0]        t_top2;
  logic [MANT_W-1:0] thresh;
  logic [MANT_W-1:0] a_win;
  logic [WIDE-1:0]   a_hi;
  logic              a_lt;
  logic [WIDE-1:0]   top_w;
  logic [WIDE-1:0]   base_w;
  logic [2:0]        wrap_diff;

  // Upper address part with its correction, then mantissa, then E zeros
  function automatic logic [WIDE-1:0] assemble(input logic [WIDE-1:0] hi,
                                               input logic x_lt,
                                               input logic addr_lt,
                                               input logic [MANT_W-1:0] mid,
                                               input logic [7:0] e);
    logic [WIDE-1:0] adj;
    adj = hi;
    if (x_lt && !addr_lt) begin
      adj = hi + WIDE'(1);
    end else if (addr_lt && !x_lt) begin
      adj = hi - WIDE'(1);
    end
    return (adj << (e + 8'(MANT_W))) | (WIDE'(mid) << e);
  endfunction

  always_comb begin
    b_fld                = meta[MANT_W-1:0];
    t_fld                = meta[2*MANT_W-3:MANT_W];
    extra_top_bit        = meta[cbd_pkg::xt_pos(MANT_W)];
    exponent_format_flag = meta[cbd_pkg::ef_pos(MANT_W)];
    e_cat                = {extra_top_bit, t_fld[H-1:0], b_fld[H-1:0]};
    if (exponent_format_flag) begin
      e_s            = 9'sd0;
      b_mid          = b_fld;
      t_low          = t_fld;
      length_carry   = (t_fld < b_fld[MANT_W-3:0]);
      length_top_bit = IS32 ? extra_top_bit : 1'b0;
    end else begin
      e_s            = 9'(MAXE) - 9'(e_cat[EXP_W-1:0]);
      b_mid          = {b_fld[MANT_W-1:H], H'(0)};
      t_low          = {t_fld[MANT_W-3:H], H'(0)};
      length_carry   = (t_fld[MANT_W-3:H] < b_fld[MANT_W-3:H]);
      length_top_bit = 1'b1;
    end
    malformed = !exponent_format_flag &&
                ((e_s < 0) ||
                 (e_s == 9'(MAXE) && b_fld != '0) ||
                 (e_s == 9'(MAXE - 1) && b_fld[MANT_W-1]));
    e_u    = (e_s < 0) ? 8'h00 : e_s[7:0];
    t_top2 = b_mid[MANT_W-1:MANT_W-2] + 2'(length_carry) + 2'(length_top_bit);
    t_full = {t_top2, t_low};
    thresh = b_mid - MANT_W'(1 << (MANT_W - 2));
    a_win  = MANT_W'(WIDE'(addr) >> e_u);
    a_hi   = WIDE'(addr) >> (e_u + 8'(MANT_W));
    a_lt   = (a_win < thresh);
    top_w  = assemble(a_hi, (t_full < thresh), a_lt, t_full, e_u);
    base_w = assemble(a_hi, (b_mid < thresh), a_lt, b_mid, e_u);
    base   = base_w[MX-1:0];
    top    = top_w[MX:0];
    wrap_diff = {1'b0, top_w[MX:MX-1]} - {2'b00, base_w[MX-1]};
    if ((e_s < 9'(MAXE - 1)) && !wrap_diff[2] && wrap_diff[1]) begin
      top[MX] = !top_w[MX];
    end
  end
endmodule

// >>> logic/cbd_capability_unit.sv
// Capability bounds unit: holds one capability and a program counter
// capability, decodes bounds, and runs checks and manipulations on command.
// Assumes an APB master with 32-bit data; commands act at the write edge.
// Contract
// - M-bit set without legacy clears tag
// - Unusable permission sets reduced to useful minimum (the build command keeps the operand's set unreduced)
// - Software perm bits two or four wide
// - Seal bit one means sealed
// - Sealed never accesses; modifying clears tag (the build command does not check the seal and can keep the tag)
// - Jump unseals and installs program counter capability
// - Link seals the return capability
// - Access needs base <= address < top
// - Inexact requested bounds give untagged result
// - Mantissa ten or fourteen bits
// - Exponent five or six bits, max 24/52
// - Exponent format set: zero exponent, stored bits
// - Exponent format clear: exponent from stored bits
// - Top two mantissa bits rebuilt from base
// - Bounds from upper address, mantissa, zeros
// - Threshold is base mantissa minus quarter range
// - Top correction from threshold comparisons
// - Base correction from threshold comparisons
// - Mantissas shifted by exponent
// - Tagged address stays representable (the link command sets the address from the operand unchecked)
// - Top msb inverted on wrapped length
// - Malformed bounds never tagged
`timescale 1ns/10ps
module cbd_capability_unit #(
  parameter int MACHINE_WIDTH  = 64,
  parameter bit LEGACY_SUPPORT = 1'b0
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cbd_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr
);
  localparam int MX    = MACHINE_WIDTH;
  localparam bit IS32  = (MX == 32);
  localparam int MANT_W = IS32 ? cbd_pkg::MANT_W_32 : cbd_pkg::MANT_W_64;
  localparam int SWPW  = IS32 ? cbd_pkg::SWPERM_W_32 : cbd_pkg::SWPERM_W_64;
  localparam int SEALB = cbd_pkg::seal_pos(MANT_W);
  localparam int PLSB  = cbd_pkg::perm_lsb(MANT_W);
  localparam int SLSB  = cbd_pkg::swperm_lsb(MANT_W);
  localparam int META_USED = SLSB + SWPW;

  if (!(MX == 32 || MX == 64) || META_USED > MX) begin : g_width_check
    $error("cbd_capability_unit: machine width must be 32 or 64");
  end

  logic [63:0]  meta_reg;
  logic [63:0]  addr_reg;
  logic         tag_reg;
  logic [63:0]  opnd_reg;
  logic [63:0]  reqb_reg;
  logic [63:0]  reqt_reg;
  logic         reqt_msb_reg;
  logic [63:0]  pcc_meta_reg;
  logic [63:0]  pcc_addr_reg;
  logic         pcc_tag_reg;
  logic [3:0]   last_op_reg;
  logic         acc_ok_reg;
  logic         acc_fault_reg;
  logic         tag_lost_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;

  logic         bus_access;
  logic         wr_fire;
  logic         rd_next;
  logic [31:0]  rd_data;
  logic         rd_hit;
  logic         hi_ok;
  logic [3:0]   cmd_op;
  logic         cmd_fire;

  logic [MX-1:0] cur_meta;
  logic [MX-1:0] cur_addr;
  logic [MX-1:0] cur_base;
  logic [MX:0]   cur_top;
  logic          cur_malformed;
  logic [MX-1:0] alt_meta;
  logic [MX-1:0] alt_addr;
  logic [MX-1:0] alt_base;
  logic [MX:0]   alt_top;
  logic          alt_malformed;
  logic          sealed;
  logic [cbd_pkg::PERM_W-1:0] cur_perm;
  logic [MX:0]   req_top;

  // Byte-lane merge of a 32-bit half
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Replace a permission field, then reduce to a useful set
  function automatic logic [63:0] set_perm(input logic [63:0] m,
                                           input logic [cbd_pkg::PERM_W-1:0] p);
    logic [cbd_pkg::PERM_W-1:0] q;
    logic [63:0] r;
    q = p;
    if (q[cbd_pkg::PERM_SYSREG] && !q[cbd_pkg::PERM_X]) begin
      q[cbd_pkg::PERM_SYSREG] = 1'b0;
    end
    if (q[cbd_pkg::PERM_C] && !q[cbd_pkg::PERM_RD] && !q[cbd_pkg::PERM_WR]) begin
      q[cbd_pkg::PERM_C] = 1'b0;
    end
    if (!LEGACY_SUPPORT) begin
      q[cbd_pkg::PERM_M] = 1'b0;
    end
    r = m;
    r[PLSB +: cbd_pkg::PERM_W] = q;
    return r;
  endfunction

  // Tag may only stand on well-formed metadata with a legal mode flag
  function automatic logic tag_legal(input logic [63:0] m, input logic mal);
    return !mal && (LEGACY_SUPPORT || !m[PLSB + cbd_pkg::PERM_M]);
  endfunction

  function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
    return hi ? v[63:32] : v[31:0];
  endfunction

  cbd_bounds_decode #(
    .MACHINE_WIDTH (MX)
  ) u_cur_decode (
    .meta      (cur_meta),
    .addr      (cur_addr),
    .base      (cur_base),
    .top       (cur_top),
    .malformed (cur_malformed)
  );

  // Second decode sees the proposed metadata or the proposed address
  cbd_bounds_decode #(
    .MACHINE_WIDTH (MX)
  ) u_alt_decode (
    .meta      (alt_meta),
    .addr      (alt_addr),
    .base      (alt_base),
    .top       (alt_top),
    .malformed (alt_malformed)
  );

  always_comb begin
    cur_meta   = meta_reg[MX-1:0];
    cur_addr   = addr_reg[MX-1:0];
    sealed     = meta_reg[SEALB];
    cur_perm   = meta_reg[PLSB +: cbd_pkg::PERM_W];
    req_top    = {reqt_msb_reg, reqt_reg[MX-1:0]};
    bus_access = psel && penable && !pready_reg;
    wr_fire    = psel && penable && pready_reg && pwrite && !pslverr_reg;
    rd_next    = bus_access && !pwrite;
    hi_ok      = !IS32;
    cmd_op     = pwdata[cbd_pkg::CMD_OP_W-1:0];
    cmd_fire   = wr_fire && (paddr == cbd_pkg::OFS_CMD) && pstrb[0];
    if (cmd_fire && cmd_op == cbd_pkg::OP_BUILD) begin
      alt_meta = opnd_reg[MX-1:0];
      alt_addr = addr_reg[MX-1:0];
    end else begin
      alt_meta = meta_reg[MX-1:0];
      alt_addr = opnd_reg[MX-1:0];
    end
  end

  // Read decode
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      cbd_pkg::OFS_CMD:     rd_data = 32'(last_op_reg);
      cbd_pkg::OFS_STATUS: begin
        rd_data[cbd_pkg::ST_TAG]       = tag_reg;
        rd_data[cbd_pkg::ST_MALFORMED] = cur_malformed;
        rd_data[cbd_pkg::ST_SEALED]    = sealed;
        rd_data[cbd_pkg::ST_ACC_OK]    = acc_ok_reg;
        rd_data[cbd_pkg::ST_ACC_FAULT] = acc_fault_reg;
        rd_data[cbd_pkg::ST_TAG_LOST]  = tag_lost_reg;
        rd_data[cbd_pkg::ST_PCC_TAG]   = pcc_tag_reg;
      end
      cbd_pkg::OFS_META_LO: rd_data = half(meta_reg, 1'b0);
      cbd_pkg::OFS_META_HI: rd_data = half(meta_reg, 1'b1);
      cbd_pkg::OFS_ADDR_LO: rd_data = half(addr_reg, 1'b0);
      cbd_pkg::OFS_ADDR_HI: rd_data = half(addr_reg, 1'b1);
      cbd_pkg::OFS_TAG:     rd_data = 32'(tag_reg);
      cbd_pkg::OFS_OPND_LO: rd_data = half(opnd_reg, 1'b0);
      cbd_pkg::OFS_OPND_HI: rd_data = half(opnd_reg, 1'b1);
      cbd_pkg::OFS_REQB_LO: rd_data = half(reqb_reg, 1'b0);
      cbd_pkg::OFS_REQB_HI: rd_data = half(reqb_reg, 1'b1);
      cbd_pkg::OFS_REQT_LO: rd_data = half(reqt_reg, 1'b0);
      cbd_pkg::OFS_REQT_HI: rd_data = half(reqt_reg, 1'b1);
      cbd_pkg::OFS_BASE_LO: rd_data = half(64'(cur_base), 1'b0);
      cbd_pkg::OFS_BASE_HI: rd_data = half(64'(cur_base), 1'b1);
      cbd_pkg::OFS_TOP_LO:  rd_data = half(64'(cur_top[MX-1:0]), 1'b0);
      cbd_pkg::OFS_TOP_HI:  rd_data = half(64'(cur_top[MX-1:0]), 1'b1);
      cbd_pkg::OFS_TOP_EXT: rd_data = 32'(cur_top[MX]);
      cbd_pkg::OFS_PCCM_LO: rd_data = half(pcc_meta_reg, 1'b0);
      cbd_pkg::OFS_PCCM_HI: rd_data = half(pcc_meta_reg, 1'b1);
      cbd_pkg::OFS_PCCA_LO: rd_data = half(pcc_addr_reg, 1'b0);
      cbd_pkg::OFS_PCCA_HI: rd_data = half(pcc_addr_reg, 1'b1);
      default:              rd_hit  = 1'b0;
    endcase
  end

  // APB answer: one wait state, then ready with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= bus_access;
      pslverr_reg <= bus_access && !rd_hit;
      prdata_reg  <= (rd_next && rd_hit) ? rd_data : 32'h0000_0000;
    end
  end

  // Operand and requested-bounds registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_reg     <= 64'h0000_0000_0000_0000;
      reqb_reg     <= 64'h0000_0000_0000_0000;
      reqt_reg     <= 64'h0000_0000_0000_0000;
      reqt_msb_reg <= 1'b0;
      last_op_reg  <= cbd_pkg::OP_NONE;
    end else if (wr_fire) begin
      case (paddr)
        cbd_pkg::OFS_OPND_LO: opnd_reg[31:0] <= merge(opnd_reg[31:0], pwdata, pstrb);
        cbd_pkg::OFS_OPND_HI: if (hi_ok) opnd_reg[63:32] <= merge(opnd_reg[63:32], pwdata, pstrb);
        cbd_pkg::OFS_REQB_LO: reqb_reg[31:0] <= merge(reqb_reg[31:0], pwdata, pstrb);
        cbd_pkg::OFS_REQB_HI: if (hi_ok) reqb_reg[63:32] <= merge(reqb_reg[63:32], pwdata, pstrb);
        cbd_pkg::OFS_REQT_LO: reqt_reg[31:0] <= merge(reqt_reg[31:0], pwdata, pstrb);
        cbd_pkg::OFS_REQT_HI: if (hi_ok) reqt_reg[63:32] <= merge(reqt_reg[63:32], pwdata, pstrb);
        cbd_pkg::OFS_CMD: begin
          if (pstrb[0]) begin
            last_op_reg <= cmd_op;
          end
          if (pstrb[1]) begin
            reqt_msb_reg <= pwdata[cbd_pkg::CMD_REQT_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Access check result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ok_reg    <= 1'b0;
      acc_fault_reg <= 1'b0;
    end else if (cmd_fire && cmd_op == cbd_pkg::OP_CHECK) begin
      acc_ok_reg    <= tag_reg && !sealed && !cur_malformed &&
                       (opnd_reg[MX-1:0] >= cur_base) &&
                       ({1'b0, opnd_reg[MX-1:0]} < cur_top);
      acc_fault_reg <= !(tag_reg && !sealed && !cur_malformed &&
                         (opnd_reg[MX-1:0] >= cur_base) &&
                         ({1'b0, opnd_reg[MX-1:0]} < cur_top));
    end
  end

  // Capability register: direct metadata and address writes drop the tag, a TAG write sets it if legal; commands transform it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg     <= 64'h0000_0000_0000_0000;
      addr_reg     <= 64'h0000_0000_0000_0000;
      tag_reg      <= 1'b0;
      tag_lost_reg <= 1'b0;
    end else if (cmd_fire) begin
      tag_lost_reg <= 1'b0;
      case (cmd_op)
        cbd_pkg::OP_SET_ADDR: begin
          addr_reg     <= 64'(opnd_reg[MX-1:0]);
          tag_reg      <= tag_reg && !sealed &&
                          (alt_base == cur_base) && (alt_top == cur_top);
          tag_lost_reg <= tag_reg && !(!sealed &&
                          (alt_base == cur_base) && (alt_top == cur_top));
        end
        cbd_pkg::OP_AND_PERM: begin
          meta_reg     <= set_perm(meta_reg, cur_perm & opnd_reg[cbd_pkg::PERM_W-1:0]);
          tag_reg      <= tag_reg && !sealed;
          tag_lost_reg <= tag_reg && sealed;
        end
        cbd_pkg::OP_BUILD: begin
          meta_reg     <= 64'(opnd_reg[MX-1:0]);
          tag_reg      <= tag_reg && tag_legal(opnd_reg, alt_malformed) &&
                          (alt_base == reqb_reg[MX-1:0]) &&
                          (alt_top == req_top) &&
                          (alt_base >= cur_base) && (alt_top <= cur_top);
          tag_lost_reg <= tag_reg && !(tag_legal(opnd_reg, alt_malformed) &&
                          (alt_base == reqb_reg[MX-1:0]) && (alt_top == req_top) &&
                          (alt_base >= cur_base) && (alt_top <= cur_top));
        end
        cbd_pkg::OP_LINK: begin
          meta_reg          <= pcc_meta_reg;
          meta_reg[SEALB]   <= 1'b1;
          addr_reg          <= 64'(opnd_reg[MX-1:0]);
          tag_reg           <= pcc_tag_reg;
        end
        default: begin
        end
      endcase
    end else if (wr_fire) begin
      case (paddr)
        cbd_pkg::OFS_META_LO: begin
          meta_reg[31:0] <= merge(meta_reg[31:0], pwdata, pstrb);
          tag_reg        <= 1'b0;
        end
        cbd_pkg::OFS_META_HI: begin
          if (hi_ok) begin
            meta_reg[63:32] <= merge(meta_reg[63:32], pwdata, pstrb);
            tag_reg         <= 1'b0;
          end
        end
        cbd_pkg::OFS_ADDR_LO: begin
          addr_reg[31:0] <= merge(addr_reg[31:0], pwdata, pstrb);
          tag_reg        <= 1'b0;
        end
        cbd_pkg::OFS_ADDR_HI: begin
          if (hi_ok) begin
            addr_reg[63:32] <= merge(addr_reg[63:32], pwdata, pstrb);
            tag_reg         <= 1'b0;
          end
        end
        cbd_pkg::OFS_TAG: begin
          if (pstrb[0]) begin
            tag_reg <= pwdata[0] && tag_legal(meta_reg, cur_malformed);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Program counter capability: a jump installs the capability unsealed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcc_meta_reg <= 64'h0000_0000_0000_0000;
      pcc_addr_reg <= 64'h0000_0000_0000_0000;
      pcc_tag_reg  <= 1'b0;
    end else if (cmd_fire && cmd_op == cbd_pkg::OP_JUMP) begin
      pcc_meta_reg        <= meta_reg;
      pcc_meta_reg[SEALB] <= 1'b0;
      pcc_addr_reg        <= addr_reg;
      pcc_tag_reg         <= tag_reg && cur_perm[cbd_pkg::PERM_X];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// >>> dv/cbd_unit_assertions.sv
// APB response checker for the capability unit.
// Assumes one wait state and one-cycle responses, as the unit's hand-over says.
`timescale 1ns/10ps
module cbd_unit_assertions (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [cbd_pkg::PADDR_W-1:0]  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [3:0]                   pstrb,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_ready_sel: assert property (pready |-> psel && penable) else $error("ready unasked");
  a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
  a_idle_quiet: assert property (!psel |-> !pready && !pslverr) else $error("idle answer");
  c_write: cover property (pready && pwrite);
  c_read: cover property (pready && !pwrite);
  c_err: cover property (pslverr);
endmodule
bind cbd_capability_unit cbd_unit_assertions cbd_unit_assertions_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> dv/cbd_pipe_model.sv
// Pipeline-side master: issues APB transfers to the capability unit.
// Assumes the unit answers with pready; the bench watchdog ends a hang.
`timescale 1ns/10ps
module cbd_pipe_model (
  input wire logic                         pclk,
  input wire logic                         pready,
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic     [cbd_pkg::PADDR_W-1:0]  paddr,
  output logic     [31:0]                  pwdata,
  output logic     [3:0]                   pstrb
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench: register traffic with a queue of expected answers.
// Assumes a 64-bit unit without the legacy mode.
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [32:0] q[$], e;
  int miscompares = 0, samples_checked = 0, seed = 32'h210395ce;
  initial forever #4 pclk = ~pclk;
  cbd_pipe_model cbd_pipe_model_i (.pclk(pclk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  cbd_capability_unit cbd_capability_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic t(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    q.push_back(x);
    cbd_pipe_model_i.xfer(w, a, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    t(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    t(1'b0, a, 32'h0, {1'b0, x});
  endtask
  task automatic test_done;
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      samples_checked++;
      if ({pslverr, prdata} !== e) begin
        miscompares++;
        $display("[ERR] %0t exp %h got %h", $time, e, {pslverr, prdata});
      end
    end
  end
  initial begin
    repeat (4000) @(posedge pclk);
    miscompares++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(cbd_pkg::OFS_STATUS, 32'h0);
    rd(cbd_pkg::OFS_BASE_HI, 32'h0);
    rd(cbd_pkg::OFS_TOP_LO, 32'h0);
    rd(cbd_pkg::OFS_TOP_EXT, 32'h1);
    t(1'b1, 8'hfc, 32'h1, {1'b1, 32'h0});
    r = $random(seed);
    wr(cbd_pkg::OFS_ADDR_LO, r);
    rd(cbd_pkg::OFS_ADDR_LO, r);
    // Mode bit without legacy support must refuse the tag
    wr(cbd_pkg::OFS_META_HI, 32'h4);
    wr(cbd_pkg::OFS_TAG, 32'h1);
    rd(cbd_pkg::OFS_STATUS, 32'h0);
    wr(cbd_pkg::OFS_META_HI, 32'h1);
    wr(cbd_pkg::OFS_TAG, 32'h1);
    wr(cbd_pkg::OFS_OPND_LO, $random(seed));
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_CHECK});
    rd(cbd_pkg::OFS_STATUS, 32'h9);
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_JUMP});
    rd(cbd_pkg::OFS_STATUS, 32'h49);
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_LINK});
    rd(cbd_pkg::OFS_STATUS, 32'h4d);
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_CHECK});
    rd(cbd_pkg::OFS_STATUS, 32'h55);
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_SET_ADDR});
    rd(cbd_pkg::OFS_STATUS, 32'h74);
    // Execute plus system-register access, then mask to the latter, which reduces to none
    wr(cbd_pkg::OFS_META_LO, 32'h0);
    wr(cbd_pkg::OFS_META_HI, 32'h3);
    wr(cbd_pkg::OFS_TAG, 32'h1);
    wr(cbd_pkg::OFS_OPND_LO, 32'h10);
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_AND_PERM});
    rd(cbd_pkg::OFS_META_HI, 32'h0);
    rd(cbd_pkg::OFS_STATUS, 32'h51);
    // Rebuild from metadata with malformed bounds loses the tag
    wr(cbd_pkg::OFS_CMD, {28'h0, cbd_pkg::OP_BUILD});
    rd(cbd_pkg::OFS_STATUS, 32'h72);
    repeat (3) @(posedge pclk);
    test_done;
  end
endmodule
